// ### verilog/spism_pkg.sv
// shared constants and types of the serial port pin and select logic
package spism_pkg;

    // ------------------------------------------------------------
    // data and select modes
    // ------------------------------------------------------------
    localparam int SPISM_W = 8;
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
    localparam int SEL_OUT_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_MODE_RST = 2'h1;
    localparam logic PORT_EN_RST = 1'b0;
    localparam logic MST_EN_RST = 1'b0;

    // ------------------------------------------------------------
    // timing and sizes
    // ------------------------------------------------------------
    // serial clock half period, in mclk cycles; at least 3 so the
    // two-stage miso sync settles inside the high phase
    localparam int SCK_HALF_DEF = 4;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int DIV_W = 16;

    typedef enum logic {
        SPISM_IDLE,
        SPISM_RUN
    } spism_mst_t;

endpackage

// ### verilog/spism_port.sv
// serial port: pin directions, select modes, master engine, slave engine, tx fifo
// Functional notes
// [R1] master drives mosi from shift msb first
// [R2] miso input as master, output as slave
// [R3] miso released when disabled or deselected
// [R4] 3-wire slave always drives miso
// [R5] sck driven only as master
// [R6] deselected 4-wire slave ignores sck
// [R7] mode 00: 3-wire, slave always selected
// [R8] 3-wire slave must be alone on bus
// [R9] mode 01: select pin is input
// [R10] mode 01 master: select fall disables master
// [R11] mode 1x: select pin outputs low bit
// [R12] software uses mode 1x only as master
// [R13] select pin routed except in mode 00
// [R14] send and receive bits move together
// [R15] master enable picks master, else slave
// [R16] mode fault clears enables, sets flag
// [R17] slave bit counter restarts on select fall
// [R18] master sck from divider, idle low
`timescale 1ns/1ps

// ------------------------------------------------------------
// tx fifo
// ------------------------------------------------------------
module spism_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } spism_fifo_t;

    spism_fifo_t f_r;
    spism_fifo_t f_nxt;
    logic push;
    logic pop;

    assign in_ready = (f_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (f_r.cnt != '0);
    assign out_data = f_r.mem[f_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        f_nxt = f_r;
        if (push) begin
            f_nxt.mem[f_r.wp] = in_data;
            f_nxt.wp = (f_r.wp == AW'(DEPTH-1)) ? '0 : f_r.wp + 1'b1;
        end
        if (pop) begin
            f_nxt.rp = (f_r.rp == AW'(DEPTH-1)) ? '0 : f_r.rp + 1'b1;
        end
        f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end
endmodule

// ------------------------------------------------------------
// port top
// ------------------------------------------------------------
module spism_port
    import spism_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic cfg_port_enable,
    input wire logic cfg_master_enable,
    input wire logic [1:0] cfg_select_mode,
    input wire logic fault_clr,
    output logic port_enable,
    output logic master_enable,
    output logic mode_fault_flag,
    output logic slave_select_routed,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [SPISM_W-1:0] tx_data,
    output logic rx_valid,
    output logic [SPISM_W-1:0] rx_data,
    input wire logic sck_in,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic slave_select_pin_i,
    output logic slave_select_pin_o,
    output logic slave_select_pin_oe
);
    typedef struct packed {
        logic ss_s1;
        logic ss_s2;
        logic ss_s3;
        logic miso_s1;
        logic miso_s2;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic port_en;
        logic mst_en;
        logic [1:0] sel_mode;
        logic fault;
        logic routed;
        logic clr;
        spism_mst_t st;
        logic [3:0] cnt;
        logic [DIV_W-1:0] div;
        logic [SPISM_W-1:0] sh;
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso_oe;
        logic ss_o;
        logic ss_oe;
        logic [SPISM_W-1:0] slv_tx;
        logic slv_full;
        logic [SPISM_W-1:0] rx;
        logic rx_vld;
    } spism_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [SPISM_W-2:0] rx;
        logic [SPISM_W-1:0] txsh;
        logic [SPISM_W-1:0] hold;
    } spism_slv_t;

    spism_state_t s_r;
    spism_state_t s_nxt;
    spism_slv_t l_r;
    spism_slv_t l_nxt;
    logic f_valid;
    logic f_pop;
    logic [SPISM_W-1:0] f_data;
    logic mst_act;
    logic slv_act;
    logic done_pulse;
    logic done_tgl_r;
    logic done_tgl_nxt;

    spism_fifo #(
        .W(SPISM_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(rst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // ------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------
    assign mst_act = s_r.port_en && s_r.mst_en; // [R15]
    assign slv_act = s_r.port_en && !s_r.mst_en; // [R15]
    assign done_pulse = s_r.done_s2 != s_r.done_s3;
    // the slave word only changes while the slave engine is held clear,
    // or in 3-wire mode where it is never cleared, whenever no loaded word is waiting (slv_full low)
    assign f_pop = f_valid && ((mst_act && s_r.st == SPISM_IDLE)
        || (slv_act && !s_r.slv_full && (s_r.clr || s_r.sel_mode == SEL_3WIRE)));

    always_comb begin
        s_nxt = s_r;
        s_nxt.ss_s1 = slave_select_pin_i;
        s_nxt.ss_s2 = s_r.ss_s1;
        s_nxt.ss_s3 = s_r.ss_s2;
        s_nxt.miso_s1 = miso_i;
        s_nxt.miso_s2 = s_r.miso_s1;
        s_nxt.done_s1 = done_tgl_r;
        s_nxt.done_s2 = s_r.done_s1;
        s_nxt.done_s3 = s_r.done_s2;
        s_nxt.rx_vld = 1'b0;

        if (fault_clr) begin
            s_nxt.fault = 1'b0;
        end
        if (cfg_wr) begin
            s_nxt.port_en = cfg_port_enable;
            s_nxt.mst_en = cfg_master_enable;
            s_nxt.sel_mode = cfg_select_mode;
        end
        // fault overrides a same-cycle write or clear
        if (s_r.sel_mode == SEL_4WIRE_IN && mst_act && s_r.ss_s3 && !s_r.ss_s2) begin // [R10]
            s_nxt.port_en = 1'b0; // [R16]
            s_nxt.mst_en = 1'b0; // [R16]
            s_nxt.fault = 1'b1; // [R16]
        end

        // master engine
        unique case (s_r.st)
            SPISM_IDLE: begin
                s_nxt.sck = 1'b0; // [R18]
                if (f_pop && mst_act) begin
                    s_nxt.sh = f_data;
                    s_nxt.mosi = f_data[SPISM_W-1]; // [R1]
                    s_nxt.cnt = '0;
                    s_nxt.div = '0;
                    s_nxt.st = SPISM_RUN;
                end
            end
            SPISM_RUN: begin
                s_nxt.div = s_r.div + 1'b1;
                if (!mst_act) begin
                    s_nxt.sck = 1'b0;
                    s_nxt.st = SPISM_IDLE;
                end else if (s_r.div == DIV_W'(SCK_HALF - 1)) begin // [R18]
                    s_nxt.div = '0;
                    s_nxt.sck = !s_r.sck;
                    if (s_r.sck) begin
                        s_nxt.sh = {s_r.sh[SPISM_W-2:0], s_r.miso_s2}; // [R2] [R14]
                        s_nxt.mosi = s_r.sh[SPISM_W-2]; // [R1] [R14]
                        s_nxt.cnt = s_r.cnt + 1'b1;
                        if (s_r.cnt == 4'(SPISM_W - 1)) begin
                            s_nxt.rx = {s_r.sh[SPISM_W-2:0], s_r.miso_s2};
                            s_nxt.rx_vld = 1'b1;
                            s_nxt.st = SPISM_IDLE;
                        end
                    end
                end
            end
        endcase

        // slave word completion and loading; a load in the cycle of a byte end wins
        if (done_pulse) begin
            s_nxt.slv_full = 1'b0;
            if (slv_act) begin
                s_nxt.rx = l_r.hold;
                s_nxt.rx_vld = 1'b1;
            end
        end
        if (f_pop && slv_act) begin
            s_nxt.slv_tx = f_data;
            s_nxt.slv_full = 1'b1;
        end

        // pin directions follow the values that take effect next
        s_nxt.clr = !(s_nxt.port_en && !s_nxt.mst_en && (s_nxt.sel_mode == SEL_3WIRE // [R7]
            || (s_nxt.sel_mode == SEL_4WIRE_IN && !s_r.ss_s2))); // [R9] [R6] [R17]
        s_nxt.miso_oe = !s_nxt.clr; // [R2] [R3] [R4]
        s_nxt.sck_oe = s_nxt.port_en && s_nxt.mst_en; // [R5]
        s_nxt.mosi_oe = s_nxt.port_en && s_nxt.mst_en; // [R1]
        s_nxt.ss_oe = s_nxt.sel_mode[SEL_OUT_BIT]; // [R11]
        s_nxt.ss_o = s_nxt.sel_mode[0]; // [R11]
        s_nxt.routed = s_nxt.sel_mode != SEL_3WIRE; // [R13]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
            s_r.port_en <= PORT_EN_RST;
            s_r.mst_en <= MST_EN_RST;
            s_r.sel_mode <= SEL_MODE_RST;
            s_r.clr <= 1'b1;
            s_r.ss_s1 <= 1'b1;
            s_r.ss_s2 <= 1'b1;
            s_r.ss_s3 <= 1'b1;
            s_r.ss_o <= SEL_MODE_RST[0];
            s_r.ss_oe <= SEL_MODE_RST[SEL_OUT_BIT];
            s_r.routed <= 1'b1;
            s_r.st <= SPISM_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial clock domain (slave)
    // ------------------------------------------------------------
    // held clear while deselected or disabled, so a select fall always
    // starts a byte at bit zero and stray sck edges do nothing
    always_comb begin
        l_nxt = l_r;
        l_nxt.cnt = l_r.cnt + 1'b1;
        l_nxt.rx = {l_r.rx[SPISM_W-3:0], mosi_i}; // [R14]
        if (l_r.cnt == '0) begin
            l_nxt.txsh = {s_r.slv_tx[SPISM_W-2:0], 1'b0};
        end else begin
            l_nxt.txsh = {l_r.txsh[SPISM_W-2:0], 1'b0};
        end
        if (l_r.cnt == 3'(SPISM_W - 1)) begin
            l_nxt.hold = {l_r.rx, mosi_i};
        end
    end

    always_ff @(posedge sck_in or posedge s_r.clr) begin
        if (s_r.clr) begin
            l_r <= '0; // [R6] [R17]
        end else begin
            l_r <= l_nxt;
        end
    end

    // byte-done toggle stays out of the cleared state: a clear on deselect
    // must not look like a finished byte to the system clock side
    assign done_tgl_nxt = (l_r.cnt == 3'(SPISM_W - 1)) ? !done_tgl_r : done_tgl_r;

    always_ff @(posedge sck_in or posedge rst) begin
        if (rst) begin
            done_tgl_r <= 1'b0;
        end else begin
            done_tgl_r <= done_tgl_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign port_enable = s_r.port_en;
    assign master_enable = s_r.mst_en;
    assign mode_fault_flag = s_r.fault;
    assign slave_select_routed = s_r.routed;
    assign rx_valid = s_r.rx_vld;
    assign rx_data = s_r.rx;
    assign sck_o = s_r.sck;
    assign sck_oe = s_r.sck_oe;
    assign mosi_o = s_r.mosi;
    assign mosi_oe = s_r.mosi_oe;
    // first bit comes from the loaded word before any sck edge
    assign miso_o = (l_r.cnt == '0) ? s_r.slv_tx[SPISM_W-1] : l_r.txsh[SPISM_W-1]; // [R4]
    assign miso_oe = s_r.miso_oe;
    assign slave_select_pin_o = s_r.ss_o;
    assign slave_select_pin_oe = s_r.ss_oe;
endmodule

// ### tb/spism_props.sv
// checker of pin directions, select modes and serial clock timing
`timescale 1ns/1ps
module spism_props
    import spism_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic cfg_port_enable,
    input wire logic cfg_master_enable,
    input wire logic [1:0] cfg_select_mode,
    input wire logic fault_clr,
    input wire logic port_enable,
    input wire logic master_enable,
    input wire logic mode_fault_flag,
    input wire logic slave_select_routed,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic slave_select_pin_i,
    input wire logic slave_select_pin_o,
    input wire logic slave_select_pin_oe
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic sck_q_r;
    logic [15:0] hold_r;
    wire slv = port_enable && !master_enable;
    wire armed = port_enable && master_enable && slave_select_routed && !slave_select_pin_oe;
    // cycles since the serial clock last changed
    always_ff @(posedge mclk) begin
        sck_q_r <= sck_o;
        hold_r <= (rst || sck_o != sck_q_r) ? 16'h0001 : hold_r + 16'h0001;
    end
    sequence ss_fall_s;
        armed && $fell(slave_select_pin_i);
    endsequence
    sequence fault_s;
        !port_enable && !master_enable && mode_fault_flag;
    endsequence
    AST_OE: assert property (sck_oe == (port_enable && master_enable) && mosi_oe == sck_oe)
        else $error("sck or mosi enable wrong");
    AST_MISO_OFF: assert property (!slv |-> !miso_oe)
        else $error("miso driven while not slave");
    AST_MISO_3W: assert property ((slv && !slave_select_routed) [*3] |-> miso_oe)
        else $error("3-wire slave not driving miso");
    AST_DESEL: assert property ((slv && slave_select_routed && slave_select_pin_i) [*5] |-> !miso_oe)
        else $error("deselected slave drives miso");
    AST_ROUTE: assert property (cfg_wr |=> slave_select_routed == ($past(cfg_select_mode) != 2'h0))
        else $error("select routing wrong");
    AST_SS_OUT: assert property (cfg_wr |=> {slave_select_pin_oe, slave_select_pin_o} == $past(cfg_select_mode))
        else $error("select output wrong");
    AST_CFG: assert property (cfg_wr ##1 !$rose(mode_fault_flag) |-> port_enable == $past(cfg_port_enable)
        && master_enable == $past(cfg_master_enable))
        else $error("enables not loaded");
    AST_FAULT: assert property (ss_fall_s |-> ##[2:5] fault_s)
        else $error("select fall did not stop master");
    AST_STICKY: assert property (mode_fault_flag && !fault_clr |=> mode_fault_flag)
        else $error("fault flag lost");
    AST_HALF: assert property ($fell(sck_o) && sck_oe |-> hold_r == 16'(SCK_HALF))
        else $error("sck high phase wrong");
endmodule

bind spism_port spism_props #(.SCK_HALF(SCK_HALF)) spism_props_inst (.*);

// ### tb/spism_peer.sv
// far side: answering slave for master tests, clocking master for slave tests
`timescale 1ns/1ps
module spism_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic miso,
    output logic so,
    output logic lk_sck,
    output logic lk_mosi
);
    // ------------------------------------------------------------
    // model
    // ------------------------------------------------------------
    logic [7:0] out_r = 8'h00;
    logic [7:0] in_r = 8'h00;
    // deselected line shows junk, never a stale bit
    assign so = sel_n ? ~out_r[7] : out_r[7];
    always @(posedge sck) in_r <= {in_r[6:0], mosi};
    // rotating, so each byte returns the loaded value; sole slave on the bus
    always @(negedge sck) if (!sel_n) out_r <= {out_r[6:0], out_r[7]};
    initial begin
        lk_sck = 1'b0;
        lk_mosi = 1'b0;
    end
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7;
        for (int i = 7; i >= 0; i--) begin
            lk_mosi = tx[i];
            #15;
            rx[i] = miso;
            lk_sck = 1'b1;
            #15;
            lk_sck = 1'b0;
        end
        lk_mosi = ~tx[0];
    endtask
endmodule

// ### tb/spism_port_tb.sv
// self-checking bench of the serial port pins and select modes
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module spism_port_tb
    import spism_pkg::*;
;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    logic mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_port_enable = 1'b0, cfg_master_enable = 1'b0;
    logic fault_clr = 1'b0, tx_valid = 1'b0, slave_select_pin_i = 1'b1;
    logic [1:0] cfg_select_mode = SEL_4WIRE_IN;
    logic [SPISM_W-1:0] tx_data = 8'h00, rx_data, got;
    logic port_enable, master_enable, mode_fault_flag, slave_select_routed, tx_ready, rx_valid, sck_o, sck_oe;
    logic mosi_o, mosi_oe, miso_o, miso_oe, slave_select_pin_o, slave_select_pin_oe, so, lk_sck, lk_mosi;
    logic sck_in, mosi_i, miso_i;
    int mismatches = 0, cmp_count = 0, rx_cnt = 0, n;
    // pe me mode ss_in | routed ss_oe ss_out sck_oe miso_oe
    logic [9:0] rows [8] = '{10'h322, 10'h3BA, 10'h3FE, 10'h376, 10'h221, 10'h274, 10'h255, 10'h174};
    always #50 mclk = ~mclk;
    assign sck_in = sck_oe ? sck_o : lk_sck;
    assign mosi_i = mosi_oe ? mosi_o : lk_mosi;
    assign miso_i = miso_oe ? miso_o : so;
    always @(posedge mclk) if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
    spism_port spism_port_inst (.*);
    spism_peer spism_peer_inst (.sck(sck_in), .mosi(mosi_i), .sel_n(~slave_select_pin_oe | slave_select_pin_o),
        .miso(miso_i), .so(so), .lk_sck(lk_sck), .lk_mosi(lk_mosi));
    task cfg(input logic [4:0] v);
        @(negedge mclk);
        {cfg_port_enable, cfg_master_enable, cfg_select_mode, slave_select_pin_i} = v;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
    endtask
    // leaves valid high so back-to-back pushes never toggle it
    task push(input logic [7:0] b);
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
    endtask
    task wait_rx(input int cnt);
        repeat (2000) if (rx_cnt < cnt) @(negedge mclk);
        `CHK("rx count", cnt, rx_cnt)
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        `CHK("reset", 8'h14, {port_enable, master_enable, mode_fault_flag, slave_select_routed, slave_select_pin_oe,
            slave_select_pin_o, sck_oe, miso_oe})
        foreach (rows[i]) begin
            cfg(rows[i][9:5]);
            repeat (6) @(negedge mclk);
            `CHK("enables", rows[i][9:8], {port_enable, master_enable})
            `CHK("pins", rows[i][4:0], {slave_select_routed, slave_select_pin_oe, slave_select_pin_o, sck_oe,
                miso_oe})
            `CHK("mosi_oe", rows[i][1], mosi_oe)
        end
        // another master pulls the select low
        cfg(5'h1B);
        slave_select_pin_i = 1'b0;
        repeat (6) @(negedge mclk);
        `CHK("fault", 4'h1, {port_enable, master_enable, sck_oe, mode_fault_flag})
        fault_clr = 1'b1;
        @(negedge mclk);
        fault_clr = 1'b0;
        slave_select_pin_i = 1'b1;
        @(negedge mclk);
        `CHK("fault clear", 1'b0, mode_fault_flag)
        // fill while off, then drain as master; select output only as master
        spism_peer_inst.out_r = 8'hA5;
        cfg(5'h0D);
        for (int k = 0; k < FIFO_DEPTH_DEF; k++) push(8'h30 + 8'(k));
        tx_valid = 1'b0;
        `CHK("full", 1'b0, tx_ready)
        cfg(5'h1D);
        wait_rx(rx_cnt + 8);
        `CHK("rx", 8'hA5, rx_data)
        `CHK("tx", 8'h37, spism_peer_inst.in_r)
        `CHK("empty", 1'b1, tx_ready)
        // slave: clocks while deselected are ignored
        cfg(5'h13);
        push(8'hC3);
        tx_valid = 1'b0;
        n = rx_cnt;
        spism_peer_inst.xfer(8'hFF, got);
        repeat (8) @(negedge mclk);
        `CHK("ignored", n, rx_cnt)
        `CHK("released", 1'b0, miso_oe)
        slave_select_pin_i = 1'b0;
        repeat (5) @(negedge mclk);
        `CHK("selected", 1'b1, miso_oe)
        spism_peer_inst.xfer(8'h5A, got);
        wait_rx(n + 1);
        `CHK("slave tx", 8'hC3, got)
        `CHK("slave rx", 8'h5A, rx_data)
        slave_select_pin_i = 1'b1;
        n = rx_cnt;
        repeat (8) @(negedge mclk);
        `CHK("deselect", n, rx_cnt)
        // 3-wire slave: always selected, drives miso without a select
        cfg(5'h11);
        push(8'h96);
        tx_valid = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("3-wire drive", 1'b1, miso_oe)
        spism_peer_inst.xfer(8'h69, got);
        wait_rx(n + 1);
        `CHK("3-wire tx", 8'h96, got)
        `CHK("3-wire rx", 8'h69, rx_data)
        // reset again in mid-run
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        `CHK("reset again", 8'h14, {port_enable, master_enable, mode_fault_flag, slave_select_routed,
            slave_select_pin_oe, slave_select_pin_o, sck_oe, miso_oe})
        end_sim;
    end
endmodule
